// ==== design/swc_top.sv ====
// sleep entry and wake-up controller with avalon-mm registers
//
// Overview of operation
// (R1) power-down is entered only by executing the sleep instruction
// (R2) sleep entry clears watchdog, clears pd, sets to, stops the oscillator
// (R3) port drive state is frozen for the whole power-down
// (R4) wake only on master clear, watchdog, or enabled interrupt
// (R5) master clear wake resets fully; watchdog and interrupt wakes continue
// (R6) pd set at power-up, cleared by sleep; to cleared on watchdog wake
// (R7) only the nine listed asynchronous interrupt sources can wake
// (R8) the instruction after sleep is prefetched during sleep execution
// (R9) wake needs the source enable, independent of global enable
// (R10) after interrupt wake run next instruction, then vector if global enabled
// (R11) software should place a no-op after sleep when needed
// (R12) watchdog is cleared on every wake-up
// (R13) pending enabled interrupt makes sleep a no-op with nothing changed
// (R14) interrupt during sleep completes sleep then wakes immediately
// (R15) software tests pd to know whether sleep took effect
// (R16) software should clear the watchdog before sleep
// (R17) watchdog reset never drives master clear pin low
// (R18) core clock stays gated off until a qualifying wake event
`timescale 1ns/1ns
module swc_top
    import swc_pkg::*;
#(
    parameter int WDT_PERIOD = SWC_WDT_PERIOD
) (
    input  wire logic                  clk_i,
    input  wire logic                  rstn_i,
    // avalon-mm slave
    input  wire logic [SWC_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // instruction sequencer
    input  wire logic                  sleep_instr_i,
    input  wire logic                  wdt_clear_instr_i,
    input  wire logic [SWC_PC_W-1:0]   pc_i,
    output logic                       prefetch_o,
    output logic      [SWC_PC_W-1:0]   prefetch_addr_o,
    output logic                       vector_o,
    output logic      [SWC_PC_W-1:0]   vector_addr_o,
    // pins and interrupt sources
    input  wire logic                  master_clear_pin_n_i,
    input  wire logic [SWC_NSRC-1:0]   irq_src_i,
    input  wire logic [7:0]            port_out_i,
    input  wire logic [7:0]            port_oe_i,
    output logic      [7:0]            port_out_o,
    output logic      [7:0]            port_oe_o,
    // power control
    output logic                       core_clk_en_o,
    output logic                       osc_drv_en_o,
    output logic                       core_reset_o,
    output logic                       wdt_reset_o,
    output logic                       master_clear_pin_oe_o
);
    ////////////////////////////////////////////////////////////////////
    swc_state_t              state_reg;
    logic [1:0]              ctrl_reg;
    logic [SWC_NSRC-1:0]     irq_en_reg;
    logic [SWC_NSRC-1:0]     irq_flag_reg;
    logic                    pd_reg;
    logic                    to_reg;
    logic [7:0]              port_out_reg;
    logic [7:0]              port_oe_reg;
    logic [SWC_PC_W-1:0]     next_pc_reg;
    logic                    prefetch_reg;
    logic                    vector_reg;
    logic                    vec_pend_reg;
    logic                    core_reset_reg;
    logic                    wdt_reset_reg;
    logic [31:0]             rdata_reg;
    logic                    ack_reg;
    logic [SWC_NSRC-1:0]     irq_sync;
    logic                    master_clear_pin_sync_n;
    logic                    wdt_to;
    logic                    wdt_clear;
    logic                    pend;
    logic                    sleep_go;
    logic                    asleep;
    logic                    wr_hit;
    logic [SWC_NSRC-1:0]     flag_clr;

    // pending if any enabled flag is set; global enable plays no part
    function automatic logic swc_pending(input logic [SWC_NSRC-1:0] f,
                                         input logic [SWC_NSRC-1:0] e);
        return |(f & e);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // asynchronous wake sources; all nine can assert without a clock
    swc_sync #(.W(SWC_NSRC)) u_irq_sync ( // R7
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .async_i     (irq_src_i),
        .reset_val_i ('0),
        .sync_o      (irq_sync)
    );

    swc_sync #(.W(1)) u_master_clear_pin_sync (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .async_i     (master_clear_pin_n_i),
        .reset_val_i (1'b1),
        .sync_o      (master_clear_pin_sync_n)
    );

    swc_wdt #(.PERIOD(WDT_PERIOD)) u_wdt (
        .clk_i     (clk_i),
        .rstn_i    (rstn_i),
        .enable_i  (ctrl_reg[SWC_CTRL_WDT_EN]),
        .clear_i   (wdt_clear),
        .timeout_o (wdt_to)
    );

    ////////////////////////////////////////////////////////////////////
    assign asleep    = (state_reg == SWC_ASLEEP);
    assign pend      = swc_pending(irq_flag_reg, irq_en_reg); // R9
    // a pending interrupt before sleep turns it into a no-op
    assign sleep_go  = (state_reg == SWC_RUN) && sleep_instr_i && !pend; // R1 R13
    assign wdt_clear = wdt_clear_instr_i || sleep_go // R2
                     || (asleep && (pend || wdt_to || !master_clear_pin_sync_n)); // R12
    assign wr_hit    = avs_write && ack_reg; // lands with waitrequest low

    // one waitrequest cycle per access; answer on the second edge
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

    // read mux, captured while waitrequest is high
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            case (avs_address)
                SWC_OFF_CTRL:     rdata_reg <= {30'h0, ctrl_reg};
                SWC_OFF_STATUS:   rdata_reg <= {29'h0, asleep, to_reg, pd_reg};
                SWC_OFF_IRQ_EN:   rdata_reg <= {23'h0, irq_en_reg};
                SWC_OFF_IRQ_FLAG: rdata_reg <= {23'h0, irq_flag_reg};
                default:          rdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata = rdata_reg;

    // control and enable registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg   <= SWC_CTRL_RST;
            irq_en_reg <= '0;
        end else if (wr_hit && avs_address == SWC_OFF_CTRL) begin
            ctrl_reg <= avs_writedata[1:0];
        end else if (wr_hit && avs_address == SWC_OFF_IRQ_EN) begin
            irq_en_reg <= avs_writedata[SWC_NSRC-1:0];
        end
    end

    // flags: write one to clear, a source still high wins over the clear
    assign flag_clr = (wr_hit && avs_address == SWC_OFF_IRQ_FLAG)
                    ? avs_writedata[SWC_NSRC-1:0] : '0;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_flag_reg <= '0;
        end else begin
            irq_flag_reg <= (irq_flag_reg & ~flag_clr) | irq_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sleep state machine
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= SWC_RUN;
        end else if (!master_clear_pin_sync_n) begin
            state_reg <= SWC_RUN; // R5
        end else begin
            case (state_reg)
                SWC_RUN:    if (sleep_go) state_reg <= SWC_ENTER;
                // entry completes even if an interrupt arrived; only master clear cuts it short
                SWC_ENTER:  state_reg <= SWC_ASLEEP; // R14
                SWC_ASLEEP: begin
                    if (pend || (ctrl_reg[SWC_CTRL_WDT_EN] && wdt_to)) begin // R4
                        state_reg <= SWC_RESUME;
                    end
                end
                SWC_RESUME: state_reg <= SWC_RUN;
                default:    state_reg <= SWC_RUN;
            endcase
        end
    end

    // pd and to status bits
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pd_reg <= 1'b1; // R6
            to_reg <= 1'b1;
        end else if (sleep_go) begin
            pd_reg <= 1'b0; // R2 R6
            to_reg <= 1'b1; // R2
        end else if (asleep && !pend && ctrl_reg[SWC_CTRL_WDT_EN] && wdt_to) begin
            to_reg <= 1'b0; // R6
        end else if (wdt_clear_instr_i) begin
            pd_reg <= 1'b1;
            to_reg <= 1'b1;
        end
    end

    // freeze port drive from entry through resume, pass through in run
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port_out_reg <= 8'h00;
            port_oe_reg  <= 8'h00;
        end else if (state_reg == SWC_RUN && !sleep_go) begin
            port_out_reg <= port_out_i;
            port_oe_reg  <= port_oe_i;
        end
    end
    assign port_out_o = port_out_reg; // R3
    assign port_oe_o  = port_oe_reg; // R3

    // prefetch of the next address while sleep executes
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prefetch_reg <= 1'b0;
            next_pc_reg  <= '0;
        end else begin
            prefetch_reg <= sleep_instr_i && state_reg == SWC_RUN; // R8
            if (sleep_instr_i && state_reg == SWC_RUN) begin
                next_pc_reg <= pc_i + 13'h0001; // R8
            end
        end
    end
    assign prefetch_o      = prefetch_reg;
    assign prefetch_addr_o = next_pc_reg;

    // vector one cycle after resume, so the prefetched word runs first
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vec_pend_reg <= 1'b0;
            vector_reg   <= 1'b0;
        end else begin
            vec_pend_reg <= asleep && pend && ctrl_reg[SWC_CTRL_GIE]; // R10
            vector_reg   <= vec_pend_reg; // R10
        end
    end
    assign vector_o      = vector_reg;
    assign vector_addr_o = SWC_IRQ_VECTOR;

    // resets: master clear is full reset; watchdog reset only when awake
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            core_reset_reg <= 1'b1;
            wdt_reset_reg  <= 1'b0;
        end else begin
            core_reset_reg <= !master_clear_pin_sync_n; // R5
            wdt_reset_reg  <= !asleep && state_reg != SWC_ENTER
                              && ctrl_reg[SWC_CTRL_WDT_EN] && wdt_to;
        end
    end
    assign core_reset_o = core_reset_reg;
    assign wdt_reset_o  = wdt_reset_reg;
    // the pin is only ever an input; a watchdog reset stays internal
    assign master_clear_pin_oe_o = 1'b0; // R17

    // clock gate and oscillator follow the sleep state
    assign core_clk_en_o = !(asleep || state_reg == SWC_ENTER); // R18
    assign osc_drv_en_o  = !asleep; // R2

    ////////////////////////////////////////////////////////////////////
    // checks
    sleep_entry_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R1
        $rose(asleep) |-> $past(state_reg) == SWC_ENTER)
        else $error("asleep without entry");
    pd_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R2
        sleep_go && master_clear_pin_sync_n |=> !pd_reg && to_reg)
        else $error("pd not cleared on sleep");
    noop_sleep_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R13
        state_reg == SWC_RUN && sleep_instr_i && pend |=> state_reg == SWC_RUN)
        else $error("sleep not a no-op with pending irq");
    port_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R3
        asleep && $past(asleep) |-> $stable(port_out_o) && $stable(port_oe_o))
        else $error("port changed while asleep");
    irq_wake_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R9
        asleep && pend && master_clear_pin_sync_n |=> state_reg == SWC_RESUME ##1 core_clk_en_o)
        else $error("no wake on enabled irq");
    clk_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R18
        asleep |-> !core_clk_en_o && !osc_drv_en_o)
        else $error("clock running while asleep");
    wdt_to_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R6
        asleep && !pend && ctrl_reg[SWC_CTRL_WDT_EN] && wdt_to && master_clear_pin_sync_n
        |=> !to_reg && state_reg == SWC_RESUME)
        else $error("to not cleared on watchdog wake");
    vector_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R10
        asleep && pend && ctrl_reg[SWC_CTRL_GIE] |-> ##2 vector_o)
        else $error("no vector after wake");
    master_clear_pin_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // R5
        !master_clear_pin_sync_n |=> core_reset_o && state_reg == SWC_RUN)
        else $error("master clear not a full reset");
    sleep_c: cover property (@(posedge clk_i) disable iff (!rstn_i) sleep_go);
    irq_wake_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
        asleep && pend);
    wdt_wake_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
        asleep && wdt_to);
endmodule

// ==== design/swc_pkg.sv ====
// shared constants for the sleep and wake controller
package swc_pkg;
    localparam int          SWC_ADDR_W         = 4;
    localparam int          SWC_PC_W           = 13;
    // register offsets (byte addresses, one word each)
    localparam logic [3:0]  SWC_OFF_CTRL       = 4'h0;
    localparam logic [3:0]  SWC_OFF_STATUS     = 4'h4;
    localparam logic [3:0]  SWC_OFF_IRQ_EN     = 4'h8;
    localparam logic [3:0]  SWC_OFF_IRQ_FLAG   = 4'hC;
    // control register fields
    localparam int          SWC_CTRL_WDT_EN    = 0;
    localparam int          SWC_CTRL_GIE       = 1;
    // status register fields
    localparam int          SWC_ST_PD          = 0;
    localparam int          SWC_ST_TO          = 1;
    localparam int          SWC_ST_ASLEEP      = 2;
    // interrupt source count: timer, capture, adc, eeprom, comparator,
    // port change, external pin, serial break, i2c slave
    localparam int          SWC_NSRC           = 9;
    localparam logic [SWC_PC_W-1:0] SWC_IRQ_VECTOR = 13'h0004;
    localparam logic [1:0]  SWC_CTRL_RST       = 2'h1;
    // watchdog period in cycles
    localparam int          SWC_WDT_PERIOD     = 4000;
    // wake cause encodings
    localparam logic [1:0]  SWC_WAKE_NONE      = 2'h0;
    localparam logic [1:0]  SWC_WAKE_WDT       = 2'h1;
    localparam logic [1:0]  SWC_WAKE_IRQ       = 2'h2;
    typedef enum logic [1:0] {
        SWC_RUN    = 2'b00,
        SWC_ENTER  = 2'b01,
        SWC_ASLEEP = 2'b10,
        SWC_RESUME = 2'b11
    } swc_state_t;
endpackage

// ==== design/swc_sync.sv ====
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ns
module swc_sync
    import swc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] async_i,
    input  wire logic [W-1:0] reset_val_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;

    // stages hold the input xor reset_val_i, so reset shows the idle level
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= async_i ^ reset_val_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts only once stage two and three agree
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_reg <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    out_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    assign sync_o = out_reg ^ reset_val_i;
endmodule

// ==== design/swc_wdt.sv ====
// watchdog counter that keeps counting through sleep
`timescale 1ns/1ns
module swc_wdt
    import swc_pkg::*;
#(
    parameter int PERIOD = SWC_WDT_PERIOD
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic enable_i,
    input  wire logic clear_i,
    output logic      timeout_o
);
    logic [15:0] cnt_reg;
    logic        to_reg;
    localparam logic [15:0] LAST = 16'(PERIOD - 1);

    // count from zero to last, pulse one cycle on wrap
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 16'h0000;
            to_reg  <= 1'b0;
        end else if (clear_i || !enable_i) begin
            cnt_reg <= 16'h0000;
            to_reg  <= 1'b0;
        end else if (cnt_reg == LAST) begin
            cnt_reg <= 16'h0000;
            to_reg  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
            to_reg  <= 1'b0;
        end
    end

    assign timeout_o = to_reg;
endmodule

// ==== test/swc_core_model.sv ====
// behavioural model of the core sequencer and the interrupt sources
`timescale 1ns/1ns
module swc_core_model
    import swc_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    input  wire logic                core_clk_en_i,
    input  wire logic                sleep_cmd_i,
    input  wire logic                watchdog_clear_instruction_cmd_i,
    input  wire logic [SWC_NSRC-1:0] irq_cmd_i,
    output logic                     sleep_instr_o,
    output logic                     wdt_clear_instr_o,
    output logic      [SWC_PC_W-1:0] pc_o,
    output logic      [SWC_NSRC-1:0] irq_src_o,
    output logic      [7:0]          port_out_o,
    output logic      [7:0]          port_oe_o
);
    logic [7:0] pattern_reg;

    ////////////////////////////////////////////////////////////////////////////
    // instruction issue: a gated core executes nothing
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sleep_instr_o     <= 1'b0;
            wdt_clear_instr_o <= 1'b0;
            pc_o              <= 13'h0100;
        end else begin
            sleep_instr_o     <= sleep_cmd_i & core_clk_en_i;
            wdt_clear_instr_o <= watchdog_clear_instruction_cmd_i & core_clk_en_i;
            // the word after sleep is a no-op, so resuming there is harmless
            if (core_clk_en_i) begin
                pc_o <= pc_o + 13'h0001;
            end
        end
    end

    // sources are asynchronous, so they move on the falling edge
    always @(negedge clk_i) begin
        irq_src_o <= irq_cmd_i;
    end

    // port requests change every cycle so a missed freeze shows at once
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pattern_reg <= 8'h5A;
        end else begin
            pattern_reg <= pattern_reg + 8'h01;
        end
    end
    assign port_out_o = pattern_reg;
    assign port_oe_o  = ~pattern_reg;
endmodule

// ==== test/sleep_wake_controller_tb_top.sv ====
// self-checking testbench for the sleep and wake controller
`timescale 1ns/1ns
module sleep_wake_controller_tb_top
    import swc_pkg::*;
;
    logic clk_i = 1'b0, rstn_i = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata_s;
    logic avs_waitrequest, wreq_s, sleep_instr_i, wdt_clear_instr_i, prefetch_o, vector_o;
    logic [12:0] pc_i, prefetch_addr_o, vector_addr_o;
    logic master_clear_pin_n_i = 1'b1, sleep_cmd = 1'b0, watchdog_clear_instruction_cmd = 1'b0;
    logic [8:0] irq_src_i, irq_cmd = 9'h000;
    logic [7:0] port_out_i, port_oe_i, port_out_o, port_oe_o;
    logic core_clk_en_o, osc_drv_en_o, core_reset_o, wdt_reset_o, master_clear_pin_oe_o;
    int fail_count = 0;
    int tests_run = 0;

    ////////////////////////////////////////////////////////////////////////////
    // short watchdog period keeps the wake scenarios brief
    swc_top #(.WDT_PERIOD(20)) dut (.clk_i, .rstn_i, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .sleep_instr_i, .wdt_clear_instr_i,
        .pc_i, .prefetch_o, .prefetch_addr_o, .vector_o, .vector_addr_o, .master_clear_pin_n_i,
        .irq_src_i, .port_out_i, .port_oe_i, .port_out_o, .port_oe_o, .core_clk_en_o,
        .osc_drv_en_o, .core_reset_o, .wdt_reset_o, .master_clear_pin_oe_o);
    swc_core_model pm (.clk_i, .rstn_i, .core_clk_en_i(core_clk_en_o), .sleep_cmd_i(sleep_cmd),
        .watchdog_clear_instruction_cmd_i(watchdog_clear_instruction_cmd), .irq_cmd_i(irq_cmd), .sleep_instr_o(sleep_instr_i),
        .wdt_clear_instr_o(wdt_clear_instr_i), .pc_o(pc_i), .irq_src_o(irq_src_i),
        .port_out_o(port_out_i), .port_oe_o(port_oe_i));

    // clock; bus answers are sampled mid-cycle, where they are settled
    always #25 clk_i = ~clk_i;
    always @(negedge clk_i) begin
        wreq_s  <= avs_waitrequest;
        rdata_s <= avs_readdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address   <= a;
        avs_read      <= !w;
        avs_write     <= w;
        avs_writedata <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wreq_s !== 1'b0 && n < 50);
        q = rdata_s;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) check("bus answer", 32'h1, 32'h0);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask

    task automatic wait_en(input logic v, input int lim);
        int n;
        n = 0;
        while (core_clk_en_o !== v && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        check("core clock enable", 32'(core_clk_en_o), 32'(v));
    endtask

    // sleep issued by the core; pf asks for the prefetch check
    task automatic do_sleep(input logic pf);
        logic [12:0] pc_s;
        @(posedge clk_i);
        sleep_cmd <= 1'b1;
        @(posedge clk_i);
        sleep_cmd <= 1'b0;
        @(negedge clk_i);
        pc_s = pc_i;
        @(negedge clk_i);
        if (pf) begin
            check("prefetch pulse", 32'(prefetch_o), 32'h1);
            check("prefetch address", 32'(prefetch_addr_o), 32'(pc_s + 13'h0001));
        end
    endtask

    task automatic drop_irqs();
        @(posedge clk_i);
        irq_cmd <= 9'h000;
        repeat (6) @(posedge clk_i);
        wr(SWC_OFF_IRQ_FLAG, 32'h1FF);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(SWC_OFF_STATUS, 32'h3, "status at power-up");
        rd(SWC_OFF_CTRL, 32'h1, "control at power-up");
        rd(SWC_OFF_IRQ_EN, 32'h0, "enables at power-up");
        wr(4'h2, 32'hFFFF_FFFF);
        rd(4'h2, 32'h0, "unmapped read");
        rd(SWC_OFF_CTRL, 32'h1, "control after unmapped write");
        check("awake without sleep", 32'(core_clk_en_o), 32'h1);
        check("clear pin never driven", 32'(master_clear_pin_oe_o), 32'h0);
    endtask

    // every source wakes once, global enable alternating
    task automatic t_irq_wake();
        logic [15:0] held;
        logic vec;
        for (int i = 0; i < SWC_NSRC; i++) begin
            wr(SWC_OFF_CTRL, {30'h0, i[0], 1'b0});
            wr(SWC_OFF_IRQ_EN, 32'h1 << i);
            do_sleep(1'b1);
            rd(SWC_OFF_STATUS, 32'h6, "asleep status");
            @(negedge clk_i);
            held = {port_oe_o, port_out_o};
            check("oscillator driver", 32'(osc_drv_en_o), 32'h0);
            repeat (3) @(negedge clk_i);
            check("port frozen", 32'({port_oe_o, port_out_o}), 32'(held));
            check("clock gated asleep", 32'(core_clk_en_o), 32'h0);
            @(posedge clk_i);
            irq_cmd <= 9'h001 << i;
            vec = 1'b0;
            repeat (12) begin
                @(negedge clk_i);
                if (vector_o === 1'b1) vec = 1'b1;
            end
            check("irq wake", 32'(core_clk_en_o), 32'h1);
            check("vector taken", 32'(vec), 32'(i[0]));
            check("vector address", 32'(vector_addr_o), 32'h0004);
            check("no reset on irq wake", 32'(core_reset_o), 32'h0);
            drop_irqs();
        end
    endtask

    // disabled sources stay silent; the watchdog wakes and restarts
    task automatic t_wdt();
        int n;
        wr(SWC_OFF_CTRL, 32'h1);
        wr(SWC_OFF_IRQ_EN, 32'h0);
        do_sleep(1'b1);
        @(posedge clk_i);
        irq_cmd <= 9'h1FF;
        rd(SWC_OFF_STATUS, 32'h6, "status after entry");
        wait_en(1'b1, 60);
        rd(SWC_OFF_STATUS, 32'h0, "status after watchdog wake");
        check("no reset on watchdog wake", 32'(core_reset_o), 32'h0);
        n = 0;
        while (wdt_reset_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        check("watchdog restarted", 32'(n >= 10 && n < 40), 32'h1);
        check("clear pin on timeout", 32'(master_clear_pin_oe_o), 32'h0);
        drop_irqs();
    endtask

    // pending enabled flag turns sleep into a no-op
    task automatic t_nop();
        wr(SWC_OFF_CTRL, 32'h0);
        wr(SWC_OFF_IRQ_EN, 32'h1);
        @(posedge clk_i);
        irq_cmd <= 9'h001;
        repeat (6) @(posedge clk_i);
        watchdog_clear_instruction_cmd <= 1'b1;
        @(posedge clk_i);
        watchdog_clear_instruction_cmd <= 1'b0;
        do_sleep(1'b0);
        repeat (4) @(negedge clk_i);
        check("no-op sleep keeps clock", 32'(core_clk_en_o), 32'h1);
        rd(SWC_OFF_STATUS, 32'h3, "status after no-op sleep");
        drop_irqs();
    endtask

    // source rising with the sleep instruction: sleep completes, then wakes
    task automatic t_late();
        wr(SWC_OFF_IRQ_EN, 32'h8);
        @(posedge clk_i);
        irq_cmd <= 9'h008;
        do_sleep(1'b1);
        check("late irq still sleeps", 32'(core_clk_en_o), 32'h0);
        wait_en(1'b1, 20);
        rd(SWC_OFF_STATUS, 32'h2, "status after late irq");
        drop_irqs();
    endtask

    // no watchdog, no sources: only the clear pin ends this sleep
    task automatic t_master_clear_pin();
        wr(SWC_OFF_IRQ_EN, 32'h0);
        do_sleep(1'b1);
        repeat (40) @(negedge clk_i);
        check("stays asleep", 32'(core_clk_en_o), 32'h0);
        @(posedge clk_i);
        master_clear_pin_n_i <= 1'b0;
        repeat (8) @(negedge clk_i);
        check("clear pin resets", 32'(core_reset_o), 32'h1);
        check("clock after clear", 32'(core_clk_en_o), 32'h1);
        check("clear pin not driven", 32'(master_clear_pin_oe_o), 32'h0);
        @(posedge clk_i);
        master_clear_pin_n_i <= 1'b1;
        repeat (8) @(negedge clk_i);
        check("reset released", 32'(core_reset_o), 32'h0);
        rd(SWC_OFF_STATUS, 32'h2, "status after clear");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        t_reset();
        t_irq_wake();
        t_wdt();
        t_nop();
        t_late();
        t_master_clear_pin();
        finish_test();
    end

    // hang guard, well above the expected several hundred cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        finish_test();
    end
endmodule
